/* File: hdl/scm_clock_ctrl.sv */
// System clock selection and low-power mode control
// Behaviour
// - select codes 0..6 give fast clock divided 1..64, code 7 slow clock.
// - keep-fast bit 1 keeps fast oscillator running after stop instruction.
// - keep-slow bit 0 keeps slow oscillator running after stop instruction.
// - switch completes after four current system ticks plus source alignment.
// - frequency codes 00,01,10,11 give 2, 4, 8 and 2 MHz.
// - new fast frequency takes effect only once stable flag is set.
// - enabling the fast oscillator clears stable flag, set again when stable.
// - fast oscillator enable is bit 0, resets to 1.
// - unimplemented register bits always read zero.
// - keep bits pick sleep, idle slow only, idle fast only or idle both clocks.
// - code 7 switches to slow clock after slow oscillator is stable.
// - return to fast clock waits for fast oscillator stabilisation.
// - sleep stops all clocks except watchdog and halts execution.
// - idle slow only stops fast clock, slow clock runs.
// - idle both clocks keeps both clocks, execution halted.
// - entering low power sets power-down flag, clears timeout flag.
// - entering low power clears watchdog counter, which resumes counting.
// - during low power memory, registers and ports hold their values.
// - keep-fast 1, keep-slow 0 enters idle fast only.
// - slow clock comes from the roughly 32 kHz slow oscillator.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "scm_consts.svh"
module scm_clock_ctrl
   import scm_pkg::*;
#(
   parameter int STAB_CYCLES = 64     // Fast oscillator settling, mclk cycles
) (
   input  wire logic       mclk,          // 25 MHz clock
   input  wire logic       rst_n,         // Asynchronous reset, active low
   input  wire logic [3:0] addr,          // Register address
   input  wire logic [7:0] wdata,         // Write data
   input  wire logic       wr,            // Write strobe
   input  wire logic       rd,            // Read strobe
   output logic      [7:0] rdata,         // Read data, cycle after rd
   input  wire logic       halt_exec,     // CPU executes stop instruction
   input  wire logic       wake,          // Wake-up event
   output logic            sys_clk_en,    // System clock tick
   output logic            fast_clk_en,   // Fast clock tick for peripherals
   output logic            slow_clk_en,   // Slow clock tick for peripherals
   output logic            slow_rc_oscillator_clk_en,   // Watchdog clock tick, always on
   output logic            cpu_run,       // CPU executing
   output logic            hold,          // Freeze memory, registers, ports
   output logic [2:0]      mode,          // Operating mode
   output logic            pdf_set,       // Set power-down flag pulse
   output logic            to_clear,      // Clear timeout flag pulse
   output logic            wdt_clear,     // Clear watchdog counter pulse
   output logic            switch_busy    // Clock switch in progress
);
   logic [1:0]  rst_sync_q;
   logic        rst_s_n;
   logic [2:0]  sel_q;
   logic        keep_fast_q;
   logic        keep_slow_q;
   logic [1:0]  freq_q;
   logic        en_q;
   logic [7:0]  rdata_q;
   scm_mode_e   mode_q;
   scm_sw_e     sw_q;
   logic [2:0]  cur_sel_q;
   logic [2:0]  sw_cnt_q;
   logic [1:0]  app_freq_q;
   logic [15:0] stab_cnt_q;
   logic        stable_q;
   logic        warm_q;
   logic        fast_on_q;
   logic [3:0]  fdiv_q;
   logic [5:0]  pre_q;
   logic [9:0]  sdiv_q;
   logic [3:0]  sstab_q;
   logic        slow_ok;
   logic        halted;
   logic        fast_need;
   logic        fast_on;
   logic        fast_tick;
   logic        slow_tick;
   logic        cur_tick;
   logic        tgt_tick;
   logic        tgt_ready;
   logic        wr_clk;
   logic        wr_osc;
   logic        pdf_q;
   logic        sel_pending;

   // Fast tick period in mclk cycles for a frequency code
   function automatic logic [3:0] fast_div(input logic [1:0] f);
      case (f)
         2'h1:    fast_div = 4'(`SCM_MCLK_HZ / `SCM_FAST_HZ_4M);
         2'h2:    fast_div = 4'(`SCM_MCLK_HZ / `SCM_FAST_HZ_8M);
         default: fast_div = 4'(`SCM_MCLK_HZ / `SCM_FAST_HZ_2M);
      endcase
   endfunction

   // Tick of the source a select code names
   function automatic logic src_tick(input logic [2:0] s, input logic ft,
                                     input logic st, input logic [5:0] pre);
      logic [5:0] m;
      m = 6'((7'h1 << s) - 7'h1);
      if (s == `SCM_SEL_SLOW) begin
         src_tick = st;
      end else begin
         src_tick = ft && ((pre & m) == m);
      end
   endfunction

   // Reset release through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_s_n = rst_sync_q[1];

   assign wr_clk = wr && (addr == `SCM_CLK_CTRL_OFS);
   assign wr_osc = wr && (addr == `SCM_OSC_CTRL_OFS);
   assign halted = (mode_q != SCM_RUN_FAST) && (mode_q != SCM_RUN_SLOW);

   // Clock control register
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sel_q       <= `SCM_SEL_RST;
         keep_fast_q <= `SCM_KEEP_RST;
         keep_slow_q <= `SCM_KEEP_RST;
      end else if (wr_clk && !halted) begin
         sel_q       <= wdata[`SCM_SEL_MSB:`SCM_SEL_LSB];
         keep_fast_q <= wdata[`SCM_KEEP_FAST_BIT];
         keep_slow_q <= wdata[`SCM_KEEP_SLOW_BIT];
      end
   end

   // oscillator control register, enable resets to 1
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         freq_q <= `SCM_FREQ_RST;
         en_q   <= `SCM_EN_RST;
      end else if (wr_osc && !halted) begin
         freq_q <= wdata[`SCM_FREQ_MSB:`SCM_FREQ_LSB];
         en_q   <= wdata[`SCM_EN_BIT];
      end
   end

   // read mux, unused bits and unmapped addresses read zero
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         rdata_q <= 8'h00;
      end else if (rd && addr == `SCM_CLK_CTRL_OFS) begin
         rdata_q <= {sel_q, 3'h0, keep_fast_q, keep_slow_q};
      end else if (rd && addr == `SCM_OSC_CTRL_OFS) begin
         rdata_q <= {4'h0, freq_q, stable_q, en_q};
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata = rdata_q;

   // fast oscillator runs when enabled or in use, unless kept off in stop
   assign sel_pending = (sel_q != cur_sel_q);
   assign fast_need   = en_q || (cur_sel_q != `SCM_SEL_SLOW)
                        || (sel_pending && sel_q != `SCM_SEL_SLOW);
   assign fast_on     = fast_need && !(halted && !keep_fast_q);

   // settling count restarts on enable or frequency change
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         fast_on_q  <= 1'b0;
         stab_cnt_q <= 16'h0000;
         stable_q   <= 1'b0;
      end else begin
         fast_on_q <= fast_on;
         // stable flag cleared first, set after settling
         if (!fast_on) begin
            stable_q   <= 1'b0;
            stab_cnt_q <= 16'h0000;
         end else if (!fast_on_q || (wr_osc && !halted
                      && wdata[`SCM_FREQ_MSB:`SCM_FREQ_LSB] != freq_q)
                      || (wr_osc && !halted && wdata[`SCM_EN_BIT] && !en_q)) begin
            stable_q   <= 1'b0;
            stab_cnt_q <= 16'(STAB_CYCLES);
         end else if (stab_cnt_q > 16'h0001) begin
            stab_cnt_q <= stab_cnt_q - 16'h0001;
         end else if (stab_cnt_q == 16'h0001) begin
            stab_cnt_q <= 16'h0000;
            stable_q   <= 1'b1;
         end
      end
   end

   // applied frequency follows the field once stable
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         app_freq_q <= `SCM_FREQ_RST;
         warm_q     <= 1'b0;
      end else begin
         if (stable_q) begin
            app_freq_q <= freq_q;
         end
         if (!fast_on) begin
            warm_q <= 1'b0;
         end else if (stable_q) begin
            warm_q <= 1'b1;
         end
      end
   end

   // fast clock tick at the applied frequency
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         fdiv_q <= 4'h0;
         pre_q  <= 6'h00;
      end else if (!warm_q) begin
         fdiv_q <= 4'h0;
      end else if (fdiv_q >= fast_div(app_freq_q) - 4'h1) begin
         fdiv_q <= 4'h0;
         pre_q  <= pre_q + 6'h01;
      end else begin
         fdiv_q <= fdiv_q + 4'h1;
      end
   end
   assign fast_tick = warm_q && (fdiv_q >= fast_div(app_freq_q) - 4'h1);

   // slow tick from the 32 kHz slow oscillator, always running
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sdiv_q  <= 10'h000;
         sstab_q <= 4'h0;
      end else if (sdiv_q == 10'(`SCM_SLOW_DIV - 1)) begin
         sdiv_q <= 10'h000;
         if (!slow_ok) begin
            sstab_q <= sstab_q + 4'h1;
         end
      end else begin
         sdiv_q <= sdiv_q + 10'h001;
      end
   end
   assign slow_tick = (sdiv_q == 10'(`SCM_SLOW_DIV - 1));
   assign slow_ok   = (sstab_q >= `SCM_SLOW_STAB);

   assign cur_tick  = src_tick(cur_sel_q, fast_tick, slow_tick, pre_q);
   assign tgt_tick  = src_tick(sel_q, fast_tick, slow_tick, pre_q);
   // slow target needs the slow oscillator stable
   // fast target needs the fast oscillator stable
   assign tgt_ready = (sel_q == `SCM_SEL_SLOW) ? slow_ok : (stable_q && warm_q);

   // count four current ticks, then swap on a target tick
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sw_q      <= SCM_SW_IDLE;
         sw_cnt_q  <= 3'h0;
         cur_sel_q <= `SCM_SEL_RST;
      end else begin
         case (sw_q)
            SCM_SW_IDLE: begin
               if (sel_pending) begin
                  sw_q     <= SCM_SW_WAIT;
                  sw_cnt_q <= 3'h0;
               end
            end
            SCM_SW_WAIT: begin
               if (sw_cnt_q == `SCM_SW_TICKS) begin
                  sw_q <= SCM_SW_READY;
               end else if (cur_tick && !halted) begin
                  sw_cnt_q <= sw_cnt_q + 3'h1;
               end
            end
            SCM_SW_READY: begin
               // swap only on a target tick, no short pulse
               if (!sel_pending) begin
                  sw_q <= SCM_SW_IDLE;
               end else if (tgt_ready && tgt_tick && !halted) begin
                  cur_sel_q <= sel_q;
                  sw_q      <= SCM_SW_IDLE;
               end
            end
            default: sw_q <= SCM_SW_IDLE;
         endcase
      end
   end
   assign switch_busy = sel_pending;

   // stop instruction picks low-power mode from keep bits
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         mode_q <= SCM_RUN_FAST;
      end else if (halt_exec && !halted) begin
         case ({keep_fast_q, keep_slow_q})
            2'b00:   mode_q <= SCM_SLEEP;
            2'b01:   mode_q <= SCM_IDLE_SLOW_ONLY;
            2'b11:   mode_q <= SCM_IDLE_BOTH_CLOCKS;
            default: mode_q <= SCM_IDLE_FAST_ONLY;
         endcase
      end else if (wake && halted) begin
         mode_q <= SCM_RUN_FAST;
      end else if (!halted) begin
         mode_q <= (cur_sel_q == `SCM_SEL_SLOW) ? SCM_RUN_SLOW : SCM_RUN_FAST;
      end
   end
   assign mode = mode_q;

   // one entry pulse sets power-down and clears timeout
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         pdf_q <= 1'b0;
      end else begin
         pdf_q <= halt_exec && !halted;
      end
   end
   assign pdf_set  = pdf_q;
   assign to_clear = pdf_q;
   // watchdog counter cleared on entry, keeps counting
   assign wdt_clear = pdf_q;

   // sleep gates every clock except the watchdog tick
   // idle slow only keeps the slow tick
   // idle both clocks keeps both ticks
   // slow tick to peripherals only when kept in stop
   assign sys_clk_en  = cur_tick && !halted;
   assign fast_clk_en = fast_tick && !(halted && !keep_fast_q);
   assign slow_clk_en = slow_tick && !(halted && !keep_slow_q);
   assign slow_rc_oscillator_clk_en = slow_tick;
   assign cpu_run     = !halted;
   assign hold        = halted;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_s_n);

   reserved_zero_a: assert property (rd |=> rdata[4:2] == 3'h0 || $past(addr) != 4'h0)
      else $error("reserved clock control bits not zero");
   osc_upper_zero_a: assert property (rdata[7:4] == 4'h0 || $past(addr) != 4'h1)
      else $error("oscillator control upper bits not zero");
   sys_source_a: assert property (sys_clk_en |-> src_tick(cur_sel_q, fast_tick,
      slow_tick, pre_q))
      else $error("system tick not from selected source");
   sleep_mode_a: assert property (halt_exec && !halted && !keep_fast_q && !keep_slow_q
      |=> mode_q == SCM_SLEEP)
      else $error("sleep not entered");
   idle_fast_a: assert property (halt_exec && !halted && keep_fast_q && !keep_slow_q
      |=> mode_q == SCM_IDLE_FAST_ONLY)
      else $error("idle fast only not entered");
   sleep_gate_a: assert property (mode_q == SCM_SLEEP |-> !sys_clk_en && !fast_clk_en
      && !slow_clk_en && slow_rc_oscillator_clk_en == slow_tick)
      else $error("clock running in sleep");
   idle_slow_a: assert property (mode_q == SCM_IDLE_SLOW_ONLY |-> !fast_clk_en
      && slow_clk_en == slow_tick && !cpu_run)
      else $error("idle slow only clocks wrong");
   entry_flags_a: assert property (halt_exec && !halted |=> pdf_set && to_clear
      && wdt_clear ##1 !pdf_set)
      else $error("entry flags not pulsed once");
   enable_clear_a: assert property (wr_osc && !halted && wdata[0] && !en_q
      |=> ##1 !stable_q)
      else $error("stable flag not cleared on enable");
   freq_apply_a: assert property ($changed(app_freq_q) |-> $past(stable_q))
      else $error("frequency applied before stable");
   swap_gate_a: assert property ($changed(cur_sel_q) |-> $past(sw_q) == SCM_SW_READY
      && $past(sw_cnt_q) == 3'h4 && $past(tgt_tick))
      else $error("switch without four ticks and alignment");
   no_runt_a: assert property (sys_clk_en |=> !sys_clk_en)
      else $error("system tick pulse too short");

   slow_switch_c: cover property (sw_q == SCM_SW_READY && sel_q == 3'h7 ##1 cur_sel_q == 3'h7);
   sleep_wake_c: cover property (mode_q == SCM_SLEEP ##1 mode_q == SCM_RUN_FAST);
   idle_both_c: cover property (mode_q == SCM_IDLE_BOTH_CLOCKS && fast_clk_en);
   restab_c: cover property ($rose(stable_q) && $changed(app_freq_q) == 1'b0);
endmodule

/* File: hdl/scm_consts.svh */
// Offsets, fields, reset values and timing counts of the clock control
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH
`define SCM_CLK_CTRL_OFS  4'h0
`define SCM_OSC_CTRL_OFS  4'h1
`define SCM_SEL_MSB       7
`define SCM_SEL_LSB       5
`define SCM_KEEP_FAST_BIT 1
`define SCM_KEEP_SLOW_BIT 0
`define SCM_FREQ_MSB      3
`define SCM_FREQ_LSB      2
`define SCM_STABLE_BIT    1
`define SCM_EN_BIT        0
`define SCM_SEL_RST       3'h0
`define SCM_KEEP_RST      1'b0
`define SCM_FREQ_RST      2'h0
`define SCM_EN_RST        1'b1
`define SCM_SEL_SLOW      3'h7
`define SCM_SW_TICKS      3'h4
`define SCM_MCLK_HZ       25000000
`define SCM_SLOW_RC_OSCILLATOR_HZ       32000
`define SCM_FAST_HZ_2M    2000000
`define SCM_FAST_HZ_4M    4000000
`define SCM_FAST_HZ_8M    8000000
`define SCM_SLOW_DIV      (`SCM_MCLK_HZ / `SCM_SLOW_RC_OSCILLATOR_HZ)
`define SCM_SLOW_STAB     4'h2
`endif

/* File: hdl/scm_pkg.sv */
// Types of the system clock and power mode control
package scm_pkg;
   typedef enum logic [2:0] {
      SCM_RUN_FAST, SCM_RUN_SLOW, SCM_SLEEP,
      SCM_IDLE_SLOW_ONLY, SCM_IDLE_BOTH_CLOCKS, SCM_IDLE_FAST_ONLY
   } scm_mode_e;
   typedef enum logic [1:0] {
      SCM_SW_IDLE, SCM_SW_WAIT, SCM_SW_READY
   } scm_sw_e;
endpackage

/* File: tb/scm_clock_ctrl_bench.sv */
// Self-checking bench for the system clock and power mode control
`timescale 1ns/1ps
`include "scm_consts.svh"
module scm_clock_ctrl_bench;
   localparam int STAB = 60;

   logic       mclk;
   logic       rst_n;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       halt_exec;
   logic       wake;
   logic       sys_clk_en;
   logic       fast_clk_en;
   logic       slow_clk_en;
   logic       slow_rc_oscillator_clk_en;
   logic       cpu_run;
   logic       hold;
   logic [2:0] mode;
   logic       pdf_set;
   logic       to_clear;
   logic       wdt_clear;
   logic       switch_busy;
   int         errors;
   int         total_checks;
   logic [7:0] d;
   int         g;
   int         cur;
   int         c[4];
   logic [2:0] lp_mode[4] = '{3'h2, 3'h3, 3'h5, 3'h4};

   scm_clock_ctrl #(.STAB_CYCLES(STAB)) scm_clock_ctrl_inst (
      .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .halt_exec(halt_exec), .wake(wake), .sys_clk_en(sys_clk_en),
      .fast_clk_en(fast_clk_en), .slow_clk_en(slow_clk_en), .slow_rc_oscillator_clk_en(slow_rc_oscillator_clk_en),
      .cpu_run(cpu_run), .hold(hold), .mode(mode), .pdf_set(pdf_set),
      .to_clear(to_clear), .wdt_clear(wdt_clear), .switch_busy(switch_busy)
   );

   // Free-running 25 MHz clock
   always #20 mclk = ~mclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Register bus cycles, strobes one cycle long
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask

   function automatic logic tick(input int which);
      case (which)
         0: tick = sys_clk_en;
         1: tick = fast_clk_en;
         2: tick = slow_clk_en;
         default: tick = slow_rc_oscillator_clk_en;
      endcase
   endfunction

   // Cycles between two consecutive ticks of one clock enable
   task automatic tick_gap(input int which, output int gap);
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      while (tick(which) !== 1'b1 && n < 5000) begin
         @(posedge mclk);
         #1 n++;
      end
      gap = 1;
      @(posedge mclk);
      #1;
      while (tick(which) !== 1'b1 && gap < 5000) begin
         @(posedge mclk);
         #1 gap++;
      end
   endtask

   function automatic int fdiv(input int f);
      fdiv = (f == 1) ? 6 : (f == 2) ? 3 : 12;
   endfunction

   // Select a new system clock code and time the switch
   task automatic sw(input logic [2:0] s, input int tar);
      int n;
      reg_wr(4'h0, {s, 5'h00});
      #1 check({31'h0, switch_busy}, 32'h1);
      n = 0;
      while (switch_busy === 1'b1 && n < 10000) begin
         @(posedge mclk);
         #1 n++;
      end
      check({31'h0, n >= 3 * cur}, 32'h1);
      check({31'h0, n <= 6 * cur + tar + 8}, 32'h1);
      tick_gap(0, g);
      check(g, tar);
      check({29'h0, mode}, (s == 3'h7) ? 32'h1 : 32'h0);
      cur = tar;
   endtask

   // Stop the run if the tests hang
   initial begin
      repeat (40000) @(posedge mclk);
      errors++;
      wrap_up();
   end

   initial begin
      mclk = 0; rst_n = 0; addr = 0; wdata = 0;
      wr = 0; rd = 0; halt_exec = 0; wake = 0;
      errors = 0; total_checks = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);

      // Reset values, unused bits, unmapped address
      reg_rd(4'h0, d); check(d, 8'h00);
      reg_rd(4'h1, d); check(d, 8'h01);
      repeat (STAB + 8) @(posedge mclk);
      reg_rd(4'h1, d); check(d, 8'h03);
      reg_wr(4'h0, 8'h1f); reg_rd(4'h0, d); check(d, 8'h03);
      reg_wr(4'h5, 8'hff); reg_rd(4'h5, d); check(d, 8'h00);
      reg_rd(4'h0, d); check(d, 8'h03);
      $display("test registers done");

      // Frequency codes; old rate holds until the stable flag returns
      for (int i = 0; i < 4; i++) begin
         reg_wr(4'h1, {6'h3c | 6'((i + 3) % 4), 2'b11});
         reg_rd(4'h1, d); check(d, {4'h0, 2'((i + 3) % 4), 2'b01});
         tick_gap(1, g); check(g, fdiv((i == 0) ? 0 : (i + 2) % 4));
         repeat (STAB + 8) @(posedge mclk);
         tick_gap(1, g); check(g, fdiv((i + 3) % 4));
      end
      reg_wr(4'h1, 8'h08); reg_wr(4'h1, 8'h09);
      reg_rd(4'h1, d); check(d, 8'h09);
      repeat (STAB + 8) @(posedge mclk);
      reg_rd(4'h1, d); check(d, 8'h0b);
      $display("test fast oscillator done");

      // Every divider code, then slow clock, then back with fast stopped
      cur = 3;
      for (int s = 1; s < 8; s++)
         sw(3'(s), (s == 7) ? `SCM_SLOW_DIV : (3 << s));
      // frequency field kept at the configured code
      reg_wr(4'h1, 8'h08);
      repeat (STAB + 8) @(posedge mclk);
      sw(3'h0, 3);
      reg_rd(4'h1, d); check({31'h0, d[1]}, 32'h1);
      reg_wr(4'h1, 8'h09);
      $display("test clock switching done");

      // Stop instruction with each pair of keep bits
      for (int k = 0; k < 4; k++) begin
         reg_wr(4'h0, {6'h00, 2'(k)});
         @(posedge mclk) halt_exec <= 1'b1;
         @(posedge mclk) halt_exec <= 1'b0;
         #1 check({29'h0, mode}, {29'h0, lp_mode[k]});
         check({28'h0, cpu_run, hold, pdf_set, to_clear}, 32'h7);
         check({31'h0, wdt_clear}, 32'h1);
         @(posedge mclk);
         #1 check({29'h0, pdf_set, to_clear, wdt_clear}, 32'h0);
         reg_wr(4'h0, 8'he0);
         c = '{0, 0, 0, 0};
         repeat (1600) begin
            @(posedge mclk);
            #1;
            for (int w = 0; w < 4; w++)
               c[w] += tick(w) === 1'b1;
         end
         check(c[0], 0);
         check({31'h0, c[1] > 0}, {31'h0, k[1]});
         check({31'h0, c[2] > 0}, {31'h0, k[0]});
         check({31'h0, c[3] > 0}, 32'h1);
         check({31'h0, hold}, 32'h1);
         @(posedge mclk) wake <= 1'b1;
         @(posedge mclk) wake <= 1'b0;
         #1 check({28'h0, mode, cpu_run}, 32'h1);
         reg_rd(4'h0, d); check(d, {6'h00, 2'(k)});
      end
      $display("test low power done");
      wrap_up();
   end
endmodule
